// ### rtl/fieldbus_master_host_config.sv
// Host configuration, cycle triggering, run-bit failure handling and mailbox control.
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master_host_config (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   cfg_wr,
  input  wire logic                   cfg_rd,
  input  wire logic            [7:0]  cfg_index,
  input  wire logic            [15:0] cfg_wdata,
  output logic                 [15:0] cfg_rdata,
  input  wire logic                   init_req,
  input  wire logic                   refresh_done,
  input  wire logic            [15:0] ctrl_word,
  input  wire logic                   mbx_wr,
  input  wire logic            [15:0] mbx_wr_data,
  output logic                        mbx_wr_ack,
  input  wire logic                   mbx_rd,
  output logic                 [15:0] mbx_rd_data,
  output logic                        mbx_rd_valid,
  output logic                        cmd_valid,
  output logic                 [15:0] cmd_data,
  output logic                        cmd_ctrl,
  input  wire logic                   cmd_ready,
  input  wire logic                   rsp_valid,
  input  wire logic            [15:0] rsp_data,
  input  wire logic                   rsp_ctrl,
  input  wire logic                   cycle_busy,
  output logic                        cycle_start,
  output logic                        out_zero,
  output logic                        out_send_en,
  output fbm_pkg::net_state_type      net_state,
  output fbm_pkg::area_type           status_area,
  output logic                 [15:0] status_base,
  output logic                 [15:0] first_status_word
);

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration words and the settings latched from them.
  logic [15:0] map_mode_q, map_mode_d, start_addr_q, start_addr_d;
  logic [15:0] exch_q, exch_d, fail_q, fail_d, rdata_d;
  fbm_pkg::cfg_type  cfg_q, cfg_d;
  fbm_pkg::area_type dec_area;
  logic [15:0]       dec_base;

  status_area_decode u_decode (
    .map_mode   (map_mode_q),
    .start_addr (start_addr_q),
    .area       (dec_area),
    .base       (dec_base)
  );

  always_comb begin
    map_mode_d   = map_mode_q;
    start_addr_d = start_addr_q;
    exch_d       = exch_q;
    fail_d       = fail_q;
    rdata_d      = cfg_rdata;
    cfg_d        = cfg_q;
    if (cfg_wr) begin
      case (cfg_index)
        fbm_pkg::IDX_STATUS_MAP_MODE:   map_mode_d   = cfg_wdata;
        fbm_pkg::IDX_STATUS_START_ADDR: start_addr_d = cfg_wdata;
        fbm_pkg::IDX_EXCHANGE_PROC:     exch_d       = cfg_wdata;
        fbm_pkg::IDX_FAIL_ACTION:       fail_d       = cfg_wdata;
        default: ;
      endcase
    end
    if (cfg_rd) begin
      case (cfg_index)
        fbm_pkg::IDX_STATUS_MAP_MODE:   rdata_d = map_mode_q;
        fbm_pkg::IDX_STATUS_START_ADDR: rdata_d = start_addr_q;
        fbm_pkg::IDX_EXCHANGE_PROC:     rdata_d = exch_q;
        fbm_pkg::IDX_FAIL_ACTION:       rdata_d = fail_q;
        default:                        rdata_d = fbm_pkg::WORD_RESET;
      endcase
    end
    if (init_req) begin
      cfg_d.user_map      = (map_mode_q == fbm_pkg::MAP_MODE_USER) &&
                            (dec_area != fbm_pkg::AREA_DEFAULT);
      cfg_d.area          = dec_area;
      cfg_d.base          = dec_base;
      cfg_d.sync_mode     = (exch_q != fbm_pkg::EXCHANGE_ASYNC);
      cfg_d.clear_on_fail = (fail_q == fbm_pkg::FAIL_CLEAR);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      map_mode_q   <= fbm_pkg::WORD_RESET;
      start_addr_q <= fbm_pkg::WORD_RESET;
      exch_q       <= fbm_pkg::WORD_RESET;
      fail_q       <= fbm_pkg::WORD_RESET;
      cfg_rdata    <= fbm_pkg::WORD_RESET;
      cfg_q        <= '{1'b0, fbm_pkg::AREA_DEFAULT,
                        fbm_pkg::DEFAULT_BASE, 1'b0, 1'b1};
    end else begin
      map_mode_q   <= map_mode_d;
      start_addr_q <= start_addr_d;
      exch_q       <= exch_d;
      fail_q       <= fail_d;
      cfg_rdata    <= rdata_d;
      cfg_q        <= cfg_d;
    end
  end

  assign status_area = cfg_q.area;
  assign status_base = cfg_q.base;

  ////////////////////////////////////////////////////////////////////////////////
  // Run and inhibit bits, cycle triggering and the network state.
  logic run_q, run_d, inh_q, inh_d, fall, start_d, zero_d, send_d;
  logic [fbm_pkg::ASYNC_CNT_W-1:0] tick_q, tick_d;
  fbm_pkg::net_state_type net_d;
  localparam logic [fbm_pkg::ASYNC_CNT_W-1:0] TICK_LAST =
    fbm_pkg::ASYNC_CNT_W'(fbm_pkg::ASYNC_CYCLES - 1);

  always_comb begin
    run_d   = refresh_done ? ctrl_word[fbm_pkg::CTL_RUN] : run_q;
    inh_d   = refresh_done ? ctrl_word[fbm_pkg::CTL_INHIBIT] : inh_q;
    fall    = refresh_done && run_q && !ctrl_word[fbm_pkg::CTL_RUN];
    tick_d  = (tick_q == TICK_LAST) ? '0 : fbm_pkg::ASYNC_CNT_W'(tick_q + 1'b1);
    net_d   = net_state;
    zero_d  = out_zero;
    send_d  = out_send_en;
    start_d = 1'b0;
    case (net_state)
      fbm_pkg::NET_OPERATE: if (inh_d || (fall && cfg_q.sync_mode)) net_d = fbm_pkg::NET_CLEAR;
      fbm_pkg::NET_CLEAR:   net_d = fbm_pkg::NET_STOP;
      fbm_pkg::NET_STOP:    if (refresh_done && run_d && !inh_d) net_d = fbm_pkg::NET_OPERATE;
      default:              net_d = fbm_pkg::NET_STOP;
    endcase
    if (cfg_q.sync_mode) begin
      start_d = refresh_done && run_d && !inh_d && !cycle_busy &&
                (net_state == fbm_pkg::NET_OPERATE);
    end else begin
      start_d = (tick_q == TICK_LAST) && !cycle_busy && !inh_q &&
                (net_state == fbm_pkg::NET_OPERATE);
    end
    if (fall) begin
      zero_d = cfg_q.sync_mode || cfg_q.clear_on_fail;
      send_d = !inh_d && (cfg_q.sync_mode || cfg_q.clear_on_fail);
    end else if (refresh_done && run_d && !run_q) begin
      zero_d = 1'b0;
      send_d = !inh_d;
    end else if (refresh_done) begin
      send_d = !inh_d && (out_send_en || run_q || zero_d);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      run_q       <= 1'b0;
      inh_q       <= 1'b0;
      tick_q      <= '0;
      net_state   <= fbm_pkg::NET_STOP;
      cycle_start <= 1'b0;
      out_zero    <= 1'b0;
      out_send_en <= 1'b1;
    end else begin
      run_q       <= run_d;
      inh_q       <= inh_d;
      tick_q      <= tick_d;
      net_state   <= net_d;
      cycle_start <= start_d;
      out_zero    <= zero_d;
      out_send_en <= send_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output and input mailboxes.
  fbm_pkg::mbx_entry_type out_push_e, out_head, in_head;
  logic out_push, out_pop, out_full, out_empty, in_push, in_pop, in_full, in_empty;
  logic [fbm_pkg::MBX_CNT_W-1:0] in_count;
  logic mbx_open, ctl_issue, load, wr_ack_d, ctl_acc_q, ctl_acc_d, rd_valid_d;
  logic [fbm_pkg::CTL_CMD_W-1:0] cmd_bits;
  logic [15:0] rd_data_d, status_d;

  mailbox_fifo #(.WIDTH(fbm_pkg::MBX_WIDTH), .DEPTH(fbm_pkg::MBX_DEPTH),
                 .CNT_W(fbm_pkg::MBX_CNT_W)) u_out_mbx (
    .clk (clk), .reset (reset), .push (out_push), .push_data (out_push_e),
    .pop (out_pop), .head (out_head), .full (out_full), .empty (out_empty), .count ()
  );

  mailbox_fifo #(.WIDTH(fbm_pkg::MBX_WIDTH), .DEPTH(fbm_pkg::MBX_DEPTH),
                 .CNT_W(fbm_pkg::MBX_CNT_W)) u_in_mbx (
    .clk (clk), .reset (reset), .push (in_push), .push_data ({1'b0, rsp_data}),
    .pop (in_pop), .head (in_head), .full (in_full), .empty (in_empty), .count (in_count)
  );

  always_comb begin
    mbx_open  = run_q && !inh_q && !in_full;
    cmd_bits  = ctrl_word[fbm_pkg::CTL_SYNC:fbm_pkg::CTL_CMD_LO];
    if (ctrl_word[fbm_pkg::CTL_UNSYNC]) cmd_bits[fbm_pkg::CTL_SYNC - fbm_pkg::CTL_CMD_LO] = 1'b0;
    if (ctrl_word[fbm_pkg::CTL_UNFRZ])  cmd_bits[fbm_pkg::CTL_FRZ - fbm_pkg::CTL_CMD_LO]  = 1'b0;
    ctl_issue = refresh_done && ctrl_word[fbm_pkg::CTL_ISSUE] && mbx_open && !out_full;
    out_push   = ctl_issue || (mbx_wr && mbx_open && !out_full);
    out_push_e = ctl_issue ? {1'b1, {(16 - fbm_pkg::CTL_CMD_W){1'b0}}, cmd_bits}
                           : {1'b0, mbx_wr_data};
    wr_ack_d   = mbx_wr && !ctl_issue && mbx_open && !out_full;
    ctl_acc_d  = refresh_done ? ctl_issue : ctl_acc_q;
    load       = !out_empty && mbx_open && (!cmd_valid || cmd_ready);
    out_pop    = load;
    in_push    = rsp_valid && !rsp_ctrl;
    in_pop     = !in_empty && (mbx_rd ||
                 (refresh_done && ctrl_word[fbm_pkg::CTL_MBX_CLR]));
    rd_valid_d = mbx_rd && !in_empty;
    rd_data_d  = rd_valid_d ? in_head.data : mbx_rd_data;
    status_d   = '0;
    status_d[fbm_pkg::ST_IN_AVAIL]  = !in_empty;
    status_d[fbm_pkg::ST_IN_FULL]   = in_full;
    status_d[fbm_pkg::ST_OUT_FULL]  = out_full;
    status_d[fbm_pkg::ST_OUT_EMPTY] = out_empty;
    status_d[fbm_pkg::ST_SYNC_MODE] = cfg_q.sync_mode;
    status_d[fbm_pkg::ST_USER_MAP]  = cfg_q.user_map;
    status_d[fbm_pkg::ST_CTL_ACC]   = ctl_acc_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_valid         <= 1'b0;
      cmd_data          <= '0;
      cmd_ctrl          <= 1'b0;
      mbx_wr_ack        <= 1'b0;
      mbx_rd_valid      <= 1'b0;
      mbx_rd_data       <= '0;
      ctl_acc_q         <= 1'b0;
      first_status_word <= '0;
    end else begin
      if (load) begin
        cmd_valid <= 1'b1;
        cmd_data  <= out_head.data;
        cmd_ctrl  <= out_head.ctrl;
      end else if (cmd_ready) begin
        cmd_valid <= 1'b0;
      end
      mbx_wr_ack        <= wr_ack_d;
      mbx_rd_valid      <= rd_valid_d;
      mbx_rd_data       <= rd_data_d;
      ctl_acc_q         <= ctl_acc_d;
      first_status_word <= status_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_cfg_held: assert property (@(posedge clk) disable iff (reset)
    !init_req |=> $stable(cfg_q)) else $error("settings changed without init");
  chk_map_user: assert property (@(posedge clk) disable iff (reset)
    init_req && map_mode_q != fbm_pkg::MAP_MODE_USER |=> status_area == fbm_pkg::AREA_DEFAULT)
    else $error("status block not on default area");
  chk_hold_decode: assert property (@(posedge clk) disable iff (reset)
    init_req && map_mode_q == fbm_pkg::MAP_MODE_USER && start_addr_q == fbm_pkg::HOLD_HI
    |=> status_area == fbm_pkg::AREA_HOLD &&
    status_base == (fbm_pkg::HOLD_HI & fbm_pkg::PREFIX_MASK))
    else $error("holding area decode wrong");
  chk_sync_start: assert property (@(posedge clk) disable iff (reset)
    cycle_start && cfg_q.sync_mode && $past(cfg_q.sync_mode) |->
    $past(refresh_done) && !$past(cycle_busy))
    else $error("sync cycle started off a refresh");
  chk_async_start: assert property (@(posedge clk) disable iff (reset)
    !cfg_q.sync_mode && tick_q == TICK_LAST && !cycle_busy && !inh_q &&
    net_state == fbm_pkg::NET_OPERATE && !init_req |=> cycle_start)
    else $error("async cycle not started");
  chk_sync_halt: assert property (@(posedge clk) disable iff (reset)
    fall && cfg_q.sync_mode && net_state == fbm_pkg::NET_OPERATE |=>
    net_state == fbm_pkg::NET_CLEAR && out_zero ##1 net_state == fbm_pkg::NET_STOP)
    else $error("sync halt did not clear then stop");
  chk_fall_hold: assert property (@(posedge clk) disable iff (reset)
    fall && !cfg_q.sync_mode && !cfg_q.clear_on_fail && !init_req |=> !out_send_en && !out_zero)
    else $error("hold action still sends");
  chk_fall_clear: assert property (@(posedge clk) disable iff (reset)
    fall && !cfg_q.sync_mode && cfg_q.clear_on_fail && !inh_d && !init_req
    |=> out_zero && out_send_en) else $error("clear action not sent");
  chk_ctl_discard: assert property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp_ctrl && !in_pop |=> in_count == $past(in_count))
    else $error("control response entered input mailbox");
  chk_full_block: assert property (@(posedge clk) disable iff (reset)
    in_full || !run_q |-> !load && !out_push) else $error("command taken while blocked");
  chk_refresh_drop: assert property (@(posedge clk) disable iff (reset)
    refresh_done && ctrl_word[fbm_pkg::CTL_MBX_CLR] && !in_empty && !in_push
    |=> in_count == $past(in_count) - 1'b1) else $error("clear bit did not drop a response");
  cov_async_cycle: cover property (@(posedge clk) disable iff (reset)
    !cfg_q.sync_mode && cycle_start);
  cov_sync_skip: cover property (@(posedge clk) disable iff (reset)
    cfg_q.sync_mode && refresh_done && cycle_busy && run_q);
  cov_in_full: cover property (@(posedge clk) disable iff (reset) in_full ##1 !in_full);
  cov_hold: cover property (@(posedge clk) disable iff (reset) fall && !out_send_en ##1 1'b1);

endmodule : fieldbus_master_host_config
`default_nettype wire

// ### rtl/fbm_pkg.sv
// Shared constants, types and register map of the fieldbus master host configuration block.
package fbm_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices of the four configuration words.
  localparam logic [7:0] IDX_STATUS_MAP_MODE   = 8'h0E;
  localparam logic [7:0] IDX_STATUS_START_ADDR = 8'h0F;
  localparam logic [7:0] IDX_EXCHANGE_PROC     = 8'h10;
  localparam logic [7:0] IDX_FAIL_ACTION       = 8'h11;

  localparam logic [15:0] WORD_RESET      = 16'h0000;
  localparam logic [15:0] MAP_MODE_USER   = 16'h0001;
  localparam logic [15:0] EXCHANGE_ASYNC  = 16'h0000;
  localparam logic [15:0] FAIL_CLEAR      = 16'h0000;

  // Start-address ranges of the 16-word slave status block.
  localparam logic [15:0] DATA_LAST = 16'h5984;
  localparam logic [15:0] IO1_LO   = 16'hA000;
  localparam logic [15:0] IO1_HI   = 16'hA220;
  localparam logic [15:0] IO2_LO   = 16'hA300;
  localparam logic [15:0] IO2_HI   = 16'hA496;
  localparam logic [15:0] HOLD_LO  = 16'hB000;
  localparam logic [15:0] HOLD_HI  = 16'hB084;
  localparam logic [15:0] LINK_LO  = 16'hC000;
  localparam logic [15:0] LINK_HI  = 16'hC048;
  localparam logic [15:0] DEFAULT_BASE = 16'h0200;
  localparam logic [15:0] PREFIX_MASK  = 16'h0FFF;

  ////////////////////////////////////////////////////////////////////////////////
  // First control word bit positions.
  localparam int CTL_RUN     = 0;
  localparam int CTL_INHIBIT = 1;
  localparam int CTL_MBX_CLR = 2;
  localparam int CTL_ISSUE   = 7;
  localparam int CTL_CMD_LO  = 9;
  localparam int CTL_UNFRZ   = 10;
  localparam int CTL_FRZ     = 11;
  localparam int CTL_UNSYNC  = 12;
  localparam int CTL_SYNC    = 13;
  localparam int CTL_CMD_W   = 5;

  // First status word bit positions.
  localparam int ST_IN_AVAIL  = 0;
  localparam int ST_IN_FULL   = 1;
  localparam int ST_OUT_FULL  = 2;
  localparam int ST_OUT_EMPTY = 3;
  localparam int ST_SYNC_MODE = 4;
  localparam int ST_USER_MAP  = 5;
  localparam int ST_CTL_ACC   = 11;

  ////////////////////////////////////////////////////////////////////////////////
  // Mailbox sizes and the free-running cycle period of asynchronous mode.
  localparam int MBX_WIDTH = 17;
  localparam int MBX_DEPTH = 8;
  localparam int MBX_CNT_W = 4;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int ASYNC_PERIOD_NS = 1000;
  localparam int ASYNC_CYCLES    = ASYNC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ASYNC_CNT_W     = 8;

  typedef enum logic [2:0] {
    AREA_DEFAULT = 3'h0,
    AREA_DATA    = 3'h1,
    AREA_IO      = 3'h2,
    AREA_HOLD    = 3'h3,
    AREA_LINK    = 3'h4
  } area_type;

  typedef enum logic [2:0] {
    NET_OPERATE = 3'h1,
    NET_CLEAR   = 3'h2,
    NET_STOP    = 3'h4
  } net_state_type;

  typedef struct packed {
    logic     user_map;
    area_type area;
    logic [15:0] base;
    logic     sync_mode;
    logic     clear_on_fail;
  } cfg_type;

  typedef struct packed {
    logic        ctrl;
    logic [15:0] data;
  } mbx_entry_type;

endpackage : fbm_pkg

// ### rtl/mailbox_fifo.sv
// Synchronous first-in first-out store used for both mailboxes.
`timescale 1ns/1ns
`default_nettype none
module mailbox_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  output logic                  full,
  output logic                  empty,
  output logic      [CNT_W-1:0] count
);

  localparam int PTR_W = CNT_W - 1;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             do_push, do_pop;

  always_comb begin
    do_push = push && (cnt_q != DEPTH_C);
    do_pop  = pop && (cnt_q != '0);
    wr_d    = do_push ? PTR_W'(wr_q + 1'b1) : wr_q;
    rd_d    = do_pop ? PTR_W'(rd_q + 1'b1) : rd_q;
    cnt_d   = cnt_q;
    if (do_push && !do_pop) begin
      cnt_d = CNT_W'(cnt_q + 1'b1);
    end else if (do_pop && !do_push) begin
      cnt_d = CNT_W'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data;
    end
  end

  assign head  = mem_q[rd_q];
  assign full  = (cnt_q == DEPTH_C);
  assign empty = (cnt_q == '0);
  assign count = cnt_q;

endmodule : mailbox_fifo
`default_nettype wire

// ### rtl/status_area_decode.sv
// Decoder of the slave status block mapping words into an area and a base.
`timescale 1ns/1ns
`default_nettype none
module status_area_decode (
  input  wire logic              [15:0] map_mode,
  input  wire logic              [15:0] start_addr,
  output fbm_pkg::area_type             area,
  output logic                   [15:0] base
);

  always_comb begin
    area = fbm_pkg::AREA_DEFAULT;
    base = fbm_pkg::DEFAULT_BASE;
    if (map_mode == fbm_pkg::MAP_MODE_USER) begin
      if (start_addr <= fbm_pkg::DATA_LAST) begin
        area = fbm_pkg::AREA_DATA;
        base = start_addr;
      end else if ((start_addr >= fbm_pkg::IO1_LO && start_addr <= fbm_pkg::IO1_HI) ||
                   (start_addr >= fbm_pkg::IO2_LO && start_addr <= fbm_pkg::IO2_HI)) begin
        area = fbm_pkg::AREA_IO;
        base = start_addr & fbm_pkg::PREFIX_MASK;
      end else if (start_addr >= fbm_pkg::HOLD_LO && start_addr <= fbm_pkg::HOLD_HI) begin
        area = fbm_pkg::AREA_HOLD;
        base = start_addr & fbm_pkg::PREFIX_MASK;
      end else if (start_addr >= fbm_pkg::LINK_LO && start_addr <= fbm_pkg::LINK_HI) begin
        area = fbm_pkg::AREA_LINK;
        base = start_addr & fbm_pkg::PREFIX_MASK;
      end
    end
  end

endmodule : status_area_decode
`default_nettype wire

// ### verif/engine_model.sv
// Behavioural protocol engine and fieldbus cycle model beside the block.
`timescale 1ns/1ns
`default_nettype none
module engine_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_data,
  input  wire logic        cmd_ctrl,
  input  wire logic        cycle_start,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic      [15:0] rsp_data,
  output logic             rsp_ctrl,
  output logic             cycle_busy
);
  logic [15:0] held;
  logic [3:0]  wait_cnt;
  logic [4:0]  busy_cnt;
  assign cycle_busy = busy_cnt != 5'h00;
  // Ready alternates so a command must be held across a stall.
  always_ff @(posedge clk) begin
    cmd_ready <= !reset && !cmd_ready;
    rsp_valid <= wait_cnt == 4'h1;
    rsp_data  <= (wait_cnt == 4'h1) ? ~held : ~rsp_data;
    if (reset) begin
      wait_cnt <= 4'h0;
      busy_cnt <= 5'h00;
    end else begin
      busy_cnt <= cycle_start ? 5'h14 : busy_cnt - {4'h0, cycle_busy};
      wait_cnt <= wait_cnt - {3'h0, wait_cnt != 4'h0};
      if (cmd_valid && cmd_ready) begin
        held     <= cmd_data;
        rsp_ctrl <= cmd_ctrl;
        wait_cnt <= 4'h3;
      end
    end
  end
endmodule : engine_model
`default_nettype wire

// ### verif/fieldbus_master_host_config_tb_top.sv
// Self-checking testbench of the fieldbus master host configuration block.
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master_host_config_tb_top;
  logic clk, reset, cfg_wr, cfg_rd, init_req, refresh_done, mbx_wr, mbx_rd, saw_clear;
  logic [7:0] cfg_index;
  logic [15:0] cfg_wdata, ctrl_word, mbx_wr_data, cmd_data, rsp_data, cfg_rdata;
  logic [15:0] mbx_rd_data, status_base, first_status_word;
  logic mbx_wr_ack, mbx_rd_valid, cmd_valid, cmd_ctrl, cmd_ready, rsp_valid, rsp_ctrl;
  logic cycle_busy, cycle_start, out_zero, out_send_en;
  fbm_pkg::net_state_type net_state;
  fbm_pkg::area_type      status_area;
  int mismatches, check_count, starts, cycles, s;
  logic [15:0] addrs [4] = '{16'hB084, 16'h1234, 16'hC049, 16'hC048};
  logic [15:0] bases [4] = '{16'h0084, 16'h1234, 16'h0200, 16'h0048};
  logic [2:0]  areas [4] = '{3'h3, 3'h1, 3'h0, 3'h4};

  fieldbus_master_host_config dut (.clk, .reset, .cfg_wr, .cfg_rd, .cfg_index, .cfg_wdata,
    .cfg_rdata, .init_req, .refresh_done, .ctrl_word, .mbx_wr, .mbx_wr_data, .mbx_wr_ack,
    .mbx_rd, .mbx_rd_data, .mbx_rd_valid, .cmd_valid, .cmd_data, .cmd_ctrl, .cmd_ready,
    .rsp_valid, .rsp_data, .rsp_ctrl, .cycle_busy, .cycle_start, .out_zero, .out_send_en,
    .net_state, .status_area, .status_base, .first_status_word);
  engine_model partner (.clk, .reset, .cmd_valid, .cmd_data, .cmd_ctrl, .cycle_start,
    .cmd_ready, .rsp_valid, .rsp_data, .rsp_ctrl, .cycle_busy);

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    cycles++;
    if (cycle_start === 1'b1) starts++;
    if (net_state === fbm_pkg::NET_CLEAR) saw_clear = 1;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    cfg_index = i;
    cfg_wdata = d;
    cfg_wr = 1;
    tick();
    cfg_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [15:0] exp);
    cfg_index = i;
    cfg_rd = 1;
    tick();
    cfg_rd = 0;
    chk("cfg_rdata", cfg_rdata, exp);
  endtask : rd
  task automatic init;
    init_req = 1;
    tick();
    init_req = 0;
    tick();
  endtask : init
  task automatic refresh(input logic [15:0] c);
    ctrl_word = c;
    refresh_done = 1;
    tick();
    refresh_done = 0;
  endtask : refresh
  task automatic mwrite(input logic [15:0] d);
    mbx_wr_data = d;
    mbx_wr = 1;
    tick();
    mbx_wr = 0;
  endtask : mwrite
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {cfg_wr, cfg_rd, init_req, refresh_done, mbx_wr, mbx_rd, saw_clear} = '0;
    {cfg_index, cfg_wdata, ctrl_word, mbx_wr_data} = '0;
    reset = 1;
    repeat (6) @(posedge clk);
    #1 reset = 0;
    chk("net_state", net_state, fbm_pkg::NET_STOP);
    chk("status_base", status_base, 16'h0200);
    wr(8'h0E, 16'h0001);
    tick();
    for (int k = 0; k < 4; k++) begin
      wr(8'h0F, addrs[k]);
      chk("pre_init_base", status_base, k == 0 ? 16'h0200 : bases[k-1]);
      init();
      chk("status_area", status_area, areas[k]);
      chk("status_base", status_base, bases[k]);
    end
    rd(8'h0F, 16'hC048);
    tick();
    rd(8'h20, 16'h0000);
    $display("config test done");
    refresh(16'h0001);
    tick();
    chk("net_state", net_state, fbm_pkg::NET_OPERATE);
    s = starts;
    repeat (210) tick();
    chk("async_starts", 16'(starts - s > 1), 16'h0001);
    mwrite(16'h1234);
    chk("mbx_wr_ack", mbx_wr_ack, 1);
    for (int k = 0; k < 20 && first_status_word[0] !== 1'b1; k++) tick();
    mbx_rd = 1;
    tick();
    mbx_rd = 0;
    chk("mbx_rd_valid", mbx_rd_valid, 1);
    chk("mbx_rd_data", mbx_rd_data, 16'hEDCB);
    refresh(16'h0281);
    tick();
    chk("ctl_accepted", first_status_word[11], 1);
    refresh(16'h0001);
    repeat (20) tick();
    chk("in_avail", first_status_word[0], 0);
    for (int k = 0; k < 9; k++) begin
      mwrite(16'(k));
      chk("fill_ack", mbx_wr_ack, 16'(k < 8));
      repeat (8) tick();
    end
    chk("in_full", first_status_word[1], 1);
    for (int k = 0; k < 8; k++) begin
      refresh(16'h0005);
      tick();
    end
    chk("flushed", first_status_word[0], 0);
    $display("mailbox test done");
    refresh(16'h0000);
    repeat (2) tick();
    chk("out_zero", out_zero, 1);
    chk("out_send_en", out_send_en, 1);
    mwrite(16'h0055);
    chk("mbx_wr_ack", mbx_wr_ack, 0);
    wr(8'h11, 16'h0001);
    init();
    refresh(16'h0001);
    tick();
    refresh(16'h0000);
    repeat (2) tick();
    chk("out_send_en", out_send_en, 0);
    chk("out_zero", out_zero, 0);
    refresh(16'h0000);
    chk("hold_kept", out_send_en, 0);
    s = starts;
    repeat (210) tick();
    chk("halt_starts", 16'(starts - s > 1), 16'h0001);
    $display("async fail test done");
    wr(8'h10, 16'h0001);
    init();
    chk("sync_mode", first_status_word[4], 1);
    s = starts;
    repeat (150) tick();
    chk("sync_idle_starts", 16'(starts - s), 16'h0000);
    refresh(16'h0001);
    tick();
    refresh(16'h0001);
    repeat (3) tick();
    chk("sync_starts", 16'(starts - s), 16'h0001);
    refresh(16'h0000);
    repeat (4) tick();
    chk("saw_clear", saw_clear, 1);
    chk("net_state", net_state, fbm_pkg::NET_STOP);
    chk("out_zero", out_zero, 1);
    $display("sync test done");
    results();
  end
endmodule : fieldbus_master_host_config_tb_top
`default_nettype wire
